// >>> hsra_host_if.v
`timescale 1ns/100ps
`default_nettype none
`include "hsra_defines.vh"

module hsra_host_if #(
	parameter [6:0] FIFO_ADDR = 7'h05,
	parameter [6:0] BAUD_ADDR = 7'h3b
) (
	// clock and reset
	input  wire       clock,
	input  wire       rstn,
	// interface select pins
	input  wire       hostIfSelectLo,
	input  wire       hostIfSelectHi,
	// spi pins
	input  wire       spiSck,
	input  wire       spiMosi,
	input  wire       slaveSelectN,
	output reg        spiMiso,
	output reg        spiMisoOe,
	// uart pins
	input  wire       uartRx,
	input  wire       uartReadTrigger,
	output reg        uartTx,
	// i2c pins and address configuration
	input  wire       i2cScl,
	input  wire       i2cSdaIn,
	output reg        i2cSdaOut,
	output reg        i2cSdaOe,
	input  wire       i2cAdr1,
	input  wire       i2cAdr2,
	input  wire       i2cAdrFromCfg,
	input  wire [1:0] i2cCfgAdr,
	// register access port
	output reg        regWrStb,
	output reg  [6:0] regWrAddr,
	output reg  [7:0] regWrData,
	output reg        regRdStb,
	output reg  [6:0] regRdAddr,
	input  wire [7:0] regRdData,
	// status
	output reg  [1:0] activeIf,
	output reg  [7:0] uartBaudSetting
);

	// ****************************************
	// functions
	// ****************************************
	function [12:0] baudDiv;
		input [7:0] s;
		reg   [2:0] e;
		reg  [12:0] m;
		begin
			e = s[`HSRA_EXP_MSB:`HSRA_EXP_LSB];
			m = {8'h00, s[`HSRA_MAN_MSB:`HSRA_MAN_LSB]};
			if (e == 3'h0)
				baudDiv = m + `HSRA_MAN_OFS0;
			else
				baudDiv = (m + `HSRA_MAN_OFS1) << (e - 3'h1);
		end
	endfunction

	function [6:0] nextAddr;
		input [6:0] a;
		begin
			nextAddr = (a == FIFO_ADDR) ? a : a + 7'h01;
		end
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	localparam NSYNC = 11;
	// idle pin levels, sck low so no false edge after reset
	localparam [NSYNC-1:0] SYNC_IDLE = 11'h6ff;
	reg [NSYNC-1:0] syncA_r;
	reg [NSYNC-1:0] syncB_r;
	always @(posedge clock)
	begin
		if (!rstn)
		begin
			syncA_r <= SYNC_IDLE;
			syncB_r <= SYNC_IDLE;
		end
		else
		begin
			syncA_r <= {hostIfSelectHi, hostIfSelectLo, spiSck, spiMosi,
				slaveSelectN, uartRx, uartReadTrigger, i2cScl, i2cSdaIn,
				i2cAdr2, i2cAdr1};
			syncB_r <= syncA_r;
		end
	end
	wire selHiS = syncB_r[10];
	wire selLoS = syncB_r[9];
	wire sckS   = syncB_r[8];
	wire mosiS  = syncB_r[7];
	wire ssnS   = syncB_r[6];
	wire rxS    = syncB_r[5];
	wire trigS  = syncB_r[4];
	wire sclS   = syncB_r[3];
	wire sdaS   = syncB_r[2];
	wire [1:0] adrLo = i2cAdrFromCfg ? i2cCfgAdr : syncB_r[1:0];

	// ****************************************
	// 27.12 MHz reference tick
	// ****************************************
	reg [16:0] refAcc_r;
	reg        refTick_r;
	wire [16:0] refSum = refAcc_r + `HSRA_REF_KHZ;
	always @(posedge clock)
	begin
		if (!rstn)
		begin
			refAcc_r  <= 17'h0_0000;
			refTick_r <= 1'b0;
		end
		else if (refSum >= `HSRA_CLK_KHZ)
		begin
			refAcc_r  <= refSum - `HSRA_CLK_KHZ;
			refTick_r <= 1'b1;
		end
		else
		begin
			refAcc_r  <= refSum;
			refTick_r <= 1'b0;
		end
	end

	// ****************************************
	// main state
	// ****************************************
	localparam I_IDLE = 3'h0;
	localparam I_ADDR = 3'h1;
	localparam I_ACK  = 3'h2;
	localparam I_RX   = 3'h3;
	localparam I_TX   = 3'h4;
	localparam I_TACK = 3'h5;

	reg  [1:0] selCnt_r;
	reg        sckPrev_r;
	reg  [2:0] spiBit_r;
	reg  [7:0] spiShift_r;
	reg  [7:0] spiOut_r;
	reg        spiFirst_r;
	reg        spiRead_r;
	reg  [6:0] spiAddr_r;
	reg        uRxBusy_r;
	reg  [3:0] uRxBit_r;
	reg [12:0] uRxTmr_r;
	reg  [7:0] uRxShift_r;
	reg        uHaveAddr_r;
	reg  [6:0] uAddr_r;
	reg        uTxBusy_r;
	reg  [3:0] uTxBit_r;
	reg [12:0] uTxTmr_r;
	reg  [8:0] uTxShift_r;
	reg        sclF_r;
	reg        sdaF_r;
	reg        sclPrev_r;
	reg        sdaPrev_r;
	reg  [2:0] sclCnt_r;
	reg  [2:0] sdaCnt_r;
	reg  [2:0] iState_r;
	reg  [3:0] iBit_r;
	reg  [7:0] iShift_r;
	reg  [7:0] iTxBuf_r;
	reg        iRw_r;
	reg        iPtrSet_r;
	reg  [6:0] iPtr_r;

	wire [12:0] bitDiv  = baudDiv(uartBaudSetting);
	wire        isSpi   = activeIf == `HSRA_IF_SPI;
	wire        isUart  = activeIf == `HSRA_IF_UART;
	wire        isI2c   = activeIf == `HSRA_IF_I2C;
	wire        sckRise = sckS & ~sckPrev_r;
	wire        sckFall = ~sckS & sckPrev_r;
	wire [7:0]  spiByte = {spiShift_r[6:0], mosiS};
	wire        sclRise = sclF_r & ~sclPrev_r;
	wire        sclFall = ~sclF_r & sclPrev_r;
	wire        iStart  = sclF_r & sclPrev_r & sdaPrev_r & ~sdaF_r;
	wire        iStop   = sclF_r & sclPrev_r & ~sdaPrev_r & sdaF_r;

	task issueWr;
		input [6:0] a;
		input [7:0] d;
		begin
			regWrStb  <= 1'b1;
			regWrAddr <= a;
			regWrData <= d;
			if (a == BAUD_ADDR)
				uartBaudSetting <= d;
		end
	endtask

	task issueRd;
		input [6:0] a;
		begin
			regRdStb  <= 1'b1;
			regRdAddr <= a;
		end
	endtask

	task startTx;
		input [7:0] d;
		begin
			uTxBusy_r  <= 1'b1;
			uTxShift_r <= {1'b1, d};
			uTxBit_r   <= 4'h0;
			uTxTmr_r   <= bitDiv - 13'h0001;
			uartTx     <= 1'b0;
		end
	endtask

	always @(posedge clock)
	begin
		if (!rstn)
		begin
			activeIf <= `HSRA_IF_NONE;
			selCnt_r <= 2'h0;
			uartBaudSetting <= `HSRA_BAUD_RST;
			regWrStb <= 1'b0;
			regWrAddr <= 7'h00;
			regWrData <= 8'h00;
			regRdStb <= 1'b0;
			regRdAddr <= 7'h00;
			spiMiso <= 1'b0;
			spiMisoOe <= 1'b0;
			uartTx <= 1'b1;
			i2cSdaOut <= 1'b0;
			i2cSdaOe <= 1'b0;
			sckPrev_r <= 1'b0;
			spiBit_r <= 3'h0;
			spiShift_r <= 8'h00;
			spiOut_r <= 8'h00;
			spiFirst_r <= 1'b1;
			spiRead_r <= 1'b0;
			spiAddr_r <= 7'h00;
			uRxBusy_r <= 1'b0;
			uRxBit_r <= 4'h0;
			uRxTmr_r <= 13'h0000;
			uRxShift_r <= 8'h00;
			uHaveAddr_r <= 1'b0;
			uAddr_r <= 7'h00;
			uTxBusy_r <= 1'b0;
			uTxBit_r <= 4'h0;
			uTxTmr_r <= 13'h0000;
			uTxShift_r <= 9'h1ff;
			sclF_r <= 1'b1;
			sdaF_r <= 1'b1;
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
			sclCnt_r <= 3'h0;
			sdaCnt_r <= 3'h0;
			iState_r <= I_IDLE;
			iBit_r <= 4'h0;
			iShift_r <= 8'h00;
			iTxBuf_r <= 8'h00;
			iRw_r <= 1'b0;
			iPtrSet_r <= 1'b0;
			iPtr_r <= 7'h00;
		end
		else
		begin
			regWrStb <= 1'b0;
			regRdStb <= 1'b0;
			// interface selection caught once pins have settled
			if (selCnt_r != `HSRA_SEL_SETTLE)
			begin
				selCnt_r <= selCnt_r + 2'h1;
				if (selCnt_r == `HSRA_SEL_SETTLE - 2'h1)
					activeIf <= {selHiS, selLoS};
			end

			// ****************************************
			// spi slave, mode 0
			// ****************************************
			sckPrev_r <= sckS;
			if (!isSpi || ssnS)
			begin
				spiBit_r   <= 3'h0;
				spiFirst_r <= 1'b1;
				spiMisoOe  <= 1'b0;
			end
			else
			begin
				spiMisoOe <= 1'b1;
				if (sckRise)
				begin
					spiShift_r <= spiByte;
					spiBit_r   <= spiBit_r + 3'h1;
					if (spiBit_r == 3'h7)
					begin
						if (spiFirst_r)
						begin
							spiFirst_r <= 1'b0;
							spiRead_r  <= spiByte[`HSRA_MODE_BIT];
							spiAddr_r  <= spiByte[7:1];
							if (spiByte[`HSRA_MODE_BIT])
								issueRd(spiByte[7:1]);
						end
						else if (spiRead_r)
							issueRd(spiByte[7:1]);
						else
						begin
							issueWr(spiAddr_r, spiByte);
							spiAddr_r <= nextAddr(spiAddr_r);
						end
					end
				end
				if (sckFall)
				begin
					spiMiso  <= spiRead_r & spiOut_r[7];
					spiOut_r <= {spiOut_r[6:0], 1'b0};
				end
			end
			if (regRdStb && isSpi)
				spiOut_r <= regRdData;

			// ****************************************
			// uart receiver
			// ****************************************
			if (!isUart)
				uRxBusy_r <= 1'b0;
			else if (!uRxBusy_r)
			begin
				if (!rxS)
				begin
					uRxBusy_r <= 1'b1;
					uRxBit_r  <= 4'h0;
					uRxTmr_r  <= bitDiv >> 1;
				end
			end
			else if (refTick_r)
			begin
				if (uRxTmr_r != 13'h0000)
					uRxTmr_r <= uRxTmr_r - 13'h0001;
				else
				begin
					uRxTmr_r <= bitDiv - 13'h0001;
					uRxBit_r <= uRxBit_r + 4'h1;
					if (uRxBit_r == 4'h0)
					begin
						if (rxS)
							uRxBusy_r <= 1'b0;
					end
					else if (uRxBit_r != 4'h9)
						uRxShift_r <= {rxS, uRxShift_r[7:1]};
					else
					begin
						uRxBusy_r <= 1'b0;
						if (rxS && !uHaveAddr_r)
						begin
							if (uRxShift_r[`HSRA_MODE_BIT])
							begin
								if (trigS)
									issueRd(uRxShift_r[7:1]);
							end
							else
							begin
								uHaveAddr_r <= 1'b1;
								uAddr_r     <= uRxShift_r[7:1];
								startTx(uRxShift_r);
							end
						end
						else if (rxS)
						begin
							uHaveAddr_r <= 1'b0;
							issueWr(uAddr_r, uRxShift_r);
						end
					end
				end
			end

			// ****************************************
			// uart transmitter
			// ****************************************
			if (regRdStb && isUart)
				startTx(regRdData);
			else if (uTxBusy_r && refTick_r)
			begin
				if (uTxTmr_r != 13'h0000)
					uTxTmr_r <= uTxTmr_r - 13'h0001;
				else if (uTxBit_r == 4'h9)
					uTxBusy_r <= 1'b0;
				else
				begin
					uTxTmr_r   <= bitDiv - 13'h0001;
					uTxBit_r   <= uTxBit_r + 4'h1;
					uartTx     <= uTxShift_r[0];
					uTxShift_r <= {1'b1, uTxShift_r[8:1]};
				end
			end

			// ****************************************
			// i2c spike filter
			// ****************************************
			if (!isI2c || sclS == sclF_r)
				sclCnt_r <= 3'h0;
			else if (sclCnt_r == `HSRA_SPIKE_CYC - 1)
			begin
				sclF_r   <= sclS;
				sclCnt_r <= 3'h0;
			end
			else
				sclCnt_r <= sclCnt_r + 3'h1;
			if (!isI2c || sdaS == sdaF_r)
				sdaCnt_r <= 3'h0;
			else if (sdaCnt_r == `HSRA_SPIKE_CYC - 1)
			begin
				sdaF_r   <= sdaS;
				sdaCnt_r <= 3'h0;
			end
			else
				sdaCnt_r <= sdaCnt_r + 3'h1;
			sclPrev_r <= sclF_r;
			sdaPrev_r <= sdaF_r;

			// ****************************************
			// i2c slave, scl is only ever sampled
			// ****************************************
			if (regRdStb && isI2c)
				iTxBuf_r <= regRdData;
			if (!isI2c || iStop)
			begin
				iState_r <= I_IDLE;
				i2cSdaOe <= 1'b0;
			end
			else if (iStart)
			begin
				iState_r  <= I_ADDR;
				iBit_r    <= 4'h0;
				iPtrSet_r <= 1'b0;
				i2cSdaOe  <= 1'b0;
			end
			else
			begin
				case (iState_r)
				I_ADDR, I_RX:
				begin
					if (sclRise)
					begin
						iShift_r <= {iShift_r[6:0], sdaF_r};
						iBit_r   <= iBit_r + 4'h1;
					end
					if (sclFall && iBit_r == 4'h8)
					begin
						if (iState_r == I_RX)
						begin
							i2cSdaOe <= 1'b1;
							iState_r <= I_ACK;
							iRw_r    <= 1'b0;
							iPtrSet_r <= 1'b1;
							if (!iPtrSet_r)
								iPtr_r <= iShift_r[6:0];
							else
							begin
								issueWr(iPtr_r, iShift_r);
								iPtr_r <= nextAddr(iPtr_r);
							end
						end
						else if (iShift_r[7:1] == {`HSRA_I2C_ADR_HI, adrLo})
						begin
							i2cSdaOe <= 1'b1;
							iState_r <= I_ACK;
							iRw_r    <= iShift_r[0];
							if (iShift_r[0])
								issueRd(iPtr_r);
						end
						else
							iState_r <= I_IDLE;
					end
				end
				I_ACK:
				begin
					if (sclFall)
					begin
						if (iRw_r)
						begin
							i2cSdaOe <= ~iTxBuf_r[7];
							iShift_r <= {iTxBuf_r[6:0], 1'b0};
							iBit_r   <= 4'h1;
							iState_r <= I_TX;
						end
						else
						begin
							i2cSdaOe <= 1'b0;
							iBit_r   <= 4'h0;
							iState_r <= I_RX;
						end
					end
				end
				I_TX:
				begin
					if (sclFall)
					begin
						if (iBit_r == 4'h8)
						begin
							i2cSdaOe <= 1'b0;
							iState_r <= I_TACK;
						end
						else
						begin
							i2cSdaOe <= ~iShift_r[7];
							iShift_r <= {iShift_r[6:0], 1'b0};
							iBit_r   <= iBit_r + 4'h1;
						end
					end
				end
				I_TACK:
				begin
					if (sclRise)
					begin
						if (sdaF_r)
							iState_r <= I_IDLE;
						else
						begin
							iPtr_r   <= nextAddr(iPtr_r);
							issueRd(nextAddr(iPtr_r));
							iState_r <= I_ACK;
						end
					end
				end
				default:
					i2cSdaOe <= 1'b0;
				endcase
			end
		end
	end

endmodule // hsra_host_if
`default_nettype wire

// >>> hsra_defines.vh
`ifndef HSRA_DEFINES_VH
`define HSRA_DEFINES_VH

// ****************************************
// host interface codes {select hi, select lo}
// ****************************************
`define HSRA_IF_UART     2'h0
`define HSRA_IF_I2C      2'h1
`define HSRA_IF_SPI      2'h2
`define HSRA_IF_NONE     2'h3
`define HSRA_SEL_SETTLE  2'h3

// ****************************************
// uart speed setting
// ****************************************
`define HSRA_BAUD_RST    8'h7a
`define HSRA_EXP_MSB     7
`define HSRA_EXP_LSB     5
`define HSRA_MAN_MSB     4
`define HSRA_MAN_LSB     0
`define HSRA_MAN_OFS0    13'h0001
`define HSRA_MAN_OFS1    13'h0021

// ****************************************
// address byte and i2c address
// ****************************************
`define HSRA_MODE_BIT    0
`define HSRA_I2C_ADR_HI  5'h0a

// ****************************************
// timing
// ****************************************
`define HSRA_CLK_KHZ     17'h0_c350
`define HSRA_REF_KHZ     17'h0_69f0
`define HSRA_CLK_NS      20
`define HSRA_SPIKE_NS    50
`define HSRA_SPIKE_CYC   ((`HSRA_SPIKE_NS + `HSRA_CLK_NS - 1) / `HSRA_CLK_NS)

`endif

// >>> hsra_host_if_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "hsra_defines.vh"

module hsra_host_if_asserts #(
	parameter [6:0] FIFO_ADDR = 7'h05,
	parameter [6:0] BAUD_ADDR = 7'h3b
) (
	// clock and reset
	input wire logic       clock,
	input wire logic       rstn,
	// pins
	input wire logic       slaveSelectN,
	input wire logic       spiSck,
	input wire logic       spiMiso,
	input wire logic       spiMisoOe,
	input wire logic       uartReadTrigger,
	input wire logic       uartTx,
	input wire logic       i2cSdaOut,
	input wire logic       i2cSdaOe,
	// register port and status
	input wire logic       regWrStb,
	input wire logic [6:0] regWrAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regRdStb,
	input wire logic [1:0] activeIf,
	input wire logic [7:0] uartBaudSetting
);
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rstn);

	// ****
	// burst tracking
	// ****
	logic inBurst_r;

	always @(posedge clock)
	begin
		if (!rstn || slaveSelectN)
			inBurst_r <= 1'b0;
		else if (regWrStb)
			inBurst_r <= 1'b1;
	end

	// ****
	// properties
	// ****
	rst_state_a: assert property (disable iff (1'b0)
		!rstn |=> uartTx && !regWrStb && uartBaudSetting == `HSRA_BAUD_RST)
		else $error("reset state wrong");
	burst_addr_a: assert property (
		regWrStb && inBurst_r |-> regWrAddr == (($past(regWrAddr) ==
		FIFO_ADDR) ? FIFO_ADDR : $past(regWrAddr) + 7'h01))
		else $error("burst address step wrong");
	sel_idle_a: assert property (
		(activeIf == `HSRA_IF_SPI && slaveSelectN) [*5] |->
		!spiMisoOe && !regWrStb)
		else $error("spi active while deselected");
	miso_fall_a: assert property ($changed(spiMiso) |-> !spiSck)
		else $error("miso changed while sck high");
	oe_spi_a: assert property (
		spiMisoOe |-> activeIf == `HSRA_IF_SPI)
		else $error("miso driven outside spi");
	sda_slave_a: assert property (
		i2cSdaOe |-> !i2cSdaOut && activeIf == `HSRA_IF_I2C)
		else $error("sda driven wrongly");
	tx_idle_a: assert property (
		activeIf != `HSRA_IF_UART |-> uartTx)
		else $error("uart tx active outside uart");
	baud_load_a: assert property (
		regWrStb && regWrAddr == BAUD_ADDR |->
		##[0:1] uartBaudSetting == regWrData)
		else $error("speed setting not loaded");
	baud_cause_a: assert property (
		$changed(uartBaudSetting) |->
		(regWrStb || $past(regWrStb)) && regWrAddr == BAUD_ADDR)
		else $error("speed setting changed without write");
	rd_trigger_a: assert property (
		regRdStb && activeIf == `HSRA_IF_UART |-> uartReadTrigger)
		else $error("uart read without trigger");
	rd_reply_a: assert property (
		regRdStb && activeIf == `HSRA_IF_UART |-> ##[1:3] !uartTx)
		else $error("uart read reply missing");

	fifo_burst_c: cover property (regWrStb && inBurst_r &&
		regWrAddr == FIFO_ADDR);
	uart_read_c: cover property (regRdStb && activeIf == `HSRA_IF_UART);
	i2c_ack_c: cover property (i2cSdaOe);
endmodule // hsra_host_if_asserts
`default_nettype wire

// >>> hsra_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module hsra_host_model (
	// clock
	input  wire logic clock,
	// spi pins
	output var  logic spiSck,
	output var  logic spiMosi,
	output var  logic slaveSelectN,
	input  wire logic spiMiso,
	// uart pins
	output var  logic uartRx,
	input  wire logic uartTx
);
	initial
	begin
		spiSck = 1'b0;
		spiMosi = 1'b0;
		slaveSelectN = 1'b1;
		uartRx = 1'b1;
	end

	// ****
	// spi stream of three bytes
	// ****
	task automatic spiSeq(input [23:0] tx, output [15:0] rx);
		integer i;
		begin
			@(negedge clock);
			slaveSelectN = 1'b0;
			for (i = 23; i >= 0; i = i - 1)
			begin
				spiMosi = tx[i];
				repeat (5) @(negedge clock);
				spiSck = 1'b1;
				if (i < 16)
					rx[i] = spiMiso;
				repeat (5) @(negedge clock);
				spiSck = 1'b0;
			end
			repeat (5) @(negedge clock);
			slaveSelectN = 1'b1;
			spiMosi = ~spiMosi;
			repeat (6) @(negedge clock);
		end
	endtask

	// ****
	// uart frames
	// ****
	task automatic uartPut(input [7:0] d, input integer bitCyc);
		integer i;
		logic [9:0] f;
		begin
			f = {1'b1, d, 1'b0};
			@(negedge clock);
			for (i = 0; i < 10; i = i + 1)
			begin
				uartRx = f[i];
				repeat (bitCyc) @(negedge clock);
			end
		end
	endtask

	task automatic uartGet(input integer bitCyc, input integer waitMax,
		output [7:0] d, output ok);
		integer i;
		begin
			ok = 1'b0;
			d = 8'h00;
			for (i = 0; i < waitMax && uartTx !== 1'b0; i = i + 1)
				@(negedge clock);
			if (uartTx === 1'b0)
			begin
				repeat (bitCyc / 2) @(negedge clock);
				for (i = 0; i < 8; i = i + 1)
				begin
					repeat (bitCyc) @(negedge clock);
					d[i] = uartTx;
				end
				repeat (bitCyc) @(negedge clock);
				ok = (uartTx === 1'b1);
			end
		end
	endtask
endmodule // hsra_host_model
`default_nettype wire

// >>> hsra_host_if_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "hsra_defines.vh"

module hsra_host_if_tb;
	localparam [6:0]   FIFO_A = 7'h05;
	localparam [6:0]   BAUD_A = 7'h3b;
	localparam integer SLOW   = 434;
	localparam integer FAST   = 41;

	logic        clock = 1'b0;
	logic        rstn, selLo, selHi, trig, scl, sdaDrv, ok, ack;
	logic  [7:0] rxByte;
	logic [15:0] rx16;
	logic [14:0] wrLog [$];
	logic  [7:0] i2cTab [4] = '{8'h00, 8'hf8, 8'h08, 8'h54};
	integer      num_errors, checks_done, rdCount, k;
	wire         spiSck, spiMosi, slaveSelectN, spiMiso, uartRx, uartTx;
	wire         i2cSdaOe, regWrStb, regRdStb;
	wire   [6:0] regWrAddr, regRdAddr;
	wire   [7:0] regWrData, regRdData, uartBaudSetting;
	wire   [1:0] activeIf;
	wire         sdaLine = i2cSdaOe ? 1'b0 : sdaDrv;

	assign regRdData = regRdStb ? {~regRdAddr, 1'b0} : 8'h00;

	always #10 clock = ~clock;

	hsra_host_if #(.FIFO_ADDR(FIFO_A), .BAUD_ADDR(BAUD_A)) DUT (
		.clock(clock), .rstn(rstn),
		.hostIfSelectLo(selLo), .hostIfSelectHi(selHi),
		.spiSck(spiSck), .spiMosi(spiMosi), .slaveSelectN(slaveSelectN),
		.spiMiso(spiMiso), .spiMisoOe(),
		.uartRx(uartRx), .uartReadTrigger(trig), .uartTx(uartTx),
		.i2cScl(scl), .i2cSdaIn(sdaLine), .i2cSdaOut(), .i2cSdaOe(i2cSdaOe),
		.i2cAdr1(1'b0), .i2cAdr2(1'b0), .i2cAdrFromCfg(1'b1),
		.i2cCfgAdr(2'b10),
		.regWrStb(regWrStb), .regWrAddr(regWrAddr), .regWrData(regWrData),
		.regRdStb(regRdStb), .regRdAddr(regRdAddr), .regRdData(regRdData),
		.activeIf(activeIf), .uartBaudSetting(uartBaudSetting));

	hsra_host_model host (
		.clock(clock), .spiSck(spiSck), .spiMosi(spiMosi),
		.slaveSelectN(slaveSelectN), .spiMiso(spiMiso),
		.uartRx(uartRx), .uartTx(uartTx));

	always @(posedge clock)
	begin
		if (regWrStb === 1'b1)
			wrLog.push_back({regWrAddr, regWrData});
		if (regRdStb === 1'b1)
			rdCount = rdCount + 1;
	end

	// ****
	// helpers
	// ****
	task check(input string what, input [15:0] exp, input [15:0] got);
		begin
			checks_done = checks_done + 1;
			if (got !== exp)
			begin
				num_errors = num_errors + 1;
				$display("[FAIL] %s expected %h seen %h", what, exp, got);
			end
		end
	endtask

	task close_out;
		begin
			if (num_errors == 0 && checks_done > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	task doReset(input [1:0] sel);
		begin
			@(negedge clock);
			rstn = 1'b0;
			{selHi, selLo} = sel;
			rdCount = 0;
			wrLog.delete();
			repeat (16) @(negedge clock);
			rstn = 1'b1;
			repeat (10) @(negedge clock);
			check("activeIf", sel, activeIf);
			check("speed", `HSRA_BAUD_RST, uartBaudSetting);
		end
	endtask

	task popWr(input [14:0] exp);
		begin
			if (wrLog.size() == 0)
				check("write count", 16'h0001, 16'h0000);
			else
				check("write", exp, wrLog.pop_front());
		end
	endtask

	task uartRead(input [6:0] a);
		begin
			fork
				host.uartPut({a, 1'b1}, FAST);
				host.uartGet(FAST, 40 * FAST, rxByte, ok);
			join
		end
	endtask

	task i2cAddr(input [7:0] b, output a);
		integer i;
		begin
			sdaDrv = 1'b0;
			repeat (25) @(negedge clock);
			for (i = 8; i >= 0; i = i - 1)
			begin
				scl = 1'b0;
				repeat (12) @(negedge clock);
				sdaDrv = (i == 0) ? 1'b1 : b[i - 1];
				repeat (13) @(negedge clock);
				scl = 1'b1;
				repeat (25) @(negedge clock);
			end
			a = (sdaLine === 1'b0);
			scl = 1'b0;
			repeat (12) @(negedge clock);
			sdaDrv = 1'b0;
			repeat (13) @(negedge clock);
			scl = 1'b1;
			repeat (12) @(negedge clock);
			sdaDrv = 1'b1;
			repeat (25) @(negedge clock);
		end
	endtask

	// ****
	// tests
	// ****
	initial
	begin
		num_errors = 0;
		checks_done = 0;
		rdCount = 0;
		rstn = 1'b0;
		selLo = 1'b0;
		selHi = 1'b1;
		trig = 1'b1;
		scl = 1'b1;
		sdaDrv = 1'b1;
		doReset(`HSRA_IF_SPI);
		host.spiSeq({BAUD_A - 7'h01, 1'b0, 16'h1122}, rx16);
		popWr({BAUD_A - 7'h01, 8'h11});
		popWr({BAUD_A, 8'h22});
		check("speed", 16'h0022, uartBaudSetting);
		host.spiSeq({FIFO_A, 1'b0, 16'h3344}, rx16);
		popWr({FIFO_A, 8'h33});
		popWr({FIFO_A, 8'h44});
		host.spiSeq({7'h12, 1'b1, 7'h13, 1'b1, 7'h14, 1'b1}, rx16);
		check("spi read", {~7'h12, 1'b0, ~7'h13, 1'b0}, rx16);
		check("spi writes", 16'h0000, wrLog.size());
		doReset(`HSRA_IF_UART);
		fork
			begin
				host.uartPut({BAUD_A, 1'b0}, SLOW);
				repeat (2 * SLOW) @(negedge clock);
				host.uartPut(8'h15, SLOW);
			end
			host.uartGet(SLOW, 20 * SLOW, rxByte, ok);
		join
		check("echo ok", 16'h0001, ok);
		check("echo", {BAUD_A, 1'b0}, rxByte);
		popWr({BAUD_A, 8'h15});
		check("speed", 16'h0015, uartBaudSetting);
		uartRead(7'h21);
		check("read ok", 16'h0001, ok);
		check("read data", {~7'h21, 1'b0}, rxByte);
		trig = 1'b0;
		uartRead(7'h22);
		check("no reply", 16'h0000, ok);
		check("read count", 16'h0001, rdCount);
		doReset(`HSRA_IF_I2C);
		for (k = 0; k < 4; k = k + 1)
		begin
			i2cAddr(i2cTab[k], ack);
			check("i2c ack", k == 3, ack);
		end
		close_out;
	end

	initial
	begin
		repeat (40000) @(posedge clock);
		num_errors = num_errors + 1;
		close_out;
	end
endmodule // hsra_host_if_tb

bind hsra_host_if hsra_host_if_asserts #(
	.FIFO_ADDR(FIFO_ADDR), .BAUD_ADDR(BAUD_ADDR)) chk (
	.clock(clock), .rstn(rstn), .slaveSelectN(slaveSelectN),
	.spiSck(spiSck), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
	.uartReadTrigger(uartReadTrigger), .uartTx(uartTx),
	.i2cSdaOut(i2cSdaOut), .i2cSdaOe(i2cSdaOe),
	.regWrStb(regWrStb), .regWrAddr(regWrAddr), .regWrData(regWrData),
	.regRdStb(regRdStb), .activeIf(activeIf),
	.uartBaudSetting(uartBaudSetting));
`default_nettype wire
